// ==== hdl/tcp_ctrl.sv ====
`timescale 1ns/1ps
// Contract
// - opcode 11, lock, 32 data, 5-bit address: write
// - opcode 11 plus 5-bit address: direct read
// - opcode 10, lock, 32 data, 3-bit address: write
// - opcode 00 triggers internal reset
// - valid write frame starts erase and program
// - damping off throughout erase and program
// - verify read; pass sends programmed block
// - verify fail: silent until next start gap
// - locked block: skip programming, repeat block
// - interval below or between zero/one ranges: bit error
// - bit count not 38/40/7 (2 or more for opcode 00): frame error
// - bit or frame error: uplink from block 1
// - 32 blocks of 33 bits, written whole
// - lock defaults 0; locked block never changes
// - block 0 configuration, blocks 1-31 user
// - startup delay adds 8192 field clocks
// - rate select: carrier/16 or carrier/32
// - encoding select: psk or manchester
// - output silence mutes modulation, keeps damping
// - last cyclic block bounds cyclic read
// - 16-32 clocks zero, 48-64 clocks one
// - direct access repeats addressed block
// - start gap enters downlink immediately
// - manchester: one rises, zero falls
module tcp_ctrl #(
	parameter int START_GAP_CYC = tcp_pkg::START_GAP_CYC_DEF,
	parameter int SD_FC = tcp_pkg::SD_FC_DEF,
	parameter int PROG_FC = tcp_pkg::PROG_FC_DEF
) (
	input wire logic CLOCK,
	input wire logic RSTN,
	input wire logic FIELD_CLK,
	input wire logic FIELD_GAP,
	input wire logic PROG_FAULT,
	output logic DAMP_ON,
	output logic MOD_OUT,
	output tcp_pkg::tcp_state_t STATE
);
	import tcp_pkg::*;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RSTN);

	// pin synchronisers
	logic [1:0] fc_sync_q;
	logic [1:0] gap_sync_q;
	logic [1:0] flt_sync_q;
	logic fc_prev_q;
	logic gap_prev_q;

	tcp_state_t st_q;
	tcp_state_t st_d;
	tcp_cfg_t cfg_q;

	logic [15:0] gap_len_q;
	logic [15:0] init_cnt_q;
	logic [15:0] prog_cnt_q;
	logic [7:0] ivl_q;
	logic [39:0] rx_q;
	logic [5:0] cnt_q;
	logic [1:0] op_q;
	logic [4:0] tgt_q;
	logic [32:0] word_q;
	logic vfy_q;

	logic [4:0] blk_q;
	logic [4:0] idx_q;
	logic rep_q;
	logic start_q;
	logic mod_restart_q;

	logic [32:0] rd_word;
	logic [32:0] cfg_word;
	tcp_wr_t wr;
	logic mod_w;
	logic bit_next;

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			fc_sync_q <= 2'h0;
			gap_sync_q <= 2'h0;
			flt_sync_q <= 2'h0;
			fc_prev_q <= 1'b0;
			gap_prev_q <= 1'b0;
		end else begin
			fc_sync_q <= {fc_sync_q[0], FIELD_CLK};
			gap_sync_q <= {gap_sync_q[0], FIELD_GAP};
			flt_sync_q <= {flt_sync_q[0], PROG_FAULT};
			fc_prev_q <= fc_sync_q[1];
			gap_prev_q <= gap_sync_q[1];
		end
	end

	wire fc_tick = fc_sync_q[1] && !fc_prev_q;
	wire gap_s = gap_sync_q[1];
	wire gap_rise = gap_s && !gap_prev_q;
	wire gap_fall = !gap_s && gap_prev_q;
	wire prog_fault = flt_sync_q[1];

	wire in_init = st_q == ST_INIT;
	wire in_up = st_q == ST_UP;
	wire in_down = st_q == ST_DOWN;
	wire in_prog = st_q == ST_PROG;
	wire in_silent = st_q == ST_SILENT;

	// start gap: a gap held long enough, in uplink or silent state only
	wire start_gap = gap_s && gap_len_q == 16'(START_GAP_CYC - 1) && (in_up || in_silent);

	// bit decoder on the field-clock count between gaps
	wire is_zero = ivl_q >= ZERO_MIN && ivl_q <= ZERO_MAX;
	wire is_one = ivl_q >= ONE_MIN && ivl_q <= ONE_MAX;
	wire err_bit = in_down && gap_rise && !(is_zero || is_one);
	wire frame_end = in_down && ivl_q > ONE_MAX;
	wire new_bit = is_one;

	// frame decode by opcode and bit count
	wire wr5 = op_q == OP_W5 && cnt_q == LEN_W5;
	wire wr3 = op_q == OP_W3 && cnt_q == LEN_W3;
	wire acc_da = op_q == OP_W5 && cnt_q == LEN_DA;
	wire rst_cmd = frame_end && op_q == OP_RST && cnt_q >= 6'h02;
	wire [4:0] frame_addr = wr3 ? {2'h0, rx_q[2:0]} : rx_q[4:0];
	wire [32:0] frame_word = wr5 ? rx_q[37:5] : rx_q[35:3];
	wire dec_wr = frame_end && (wr5 || wr3);
	wire dec_lock = dec_wr && rd_word[LOCK_POS];
	wire go_prog = dec_wr && !rd_word[LOCK_POS];
	wire dec_rep = frame_end && (acc_da || dec_lock);

	// programming sequence
	wire prog_due = in_prog && prog_cnt_q == 16'(PROG_FC) && !vfy_q;
	wire vfy_ok = in_prog && vfy_q && rd_word == word_q;
	wire vfy_bad = in_prog && vfy_q && rd_word != word_q;

	// initialisation length depends on the freshly loaded delay select
	wire [15:0] init_len = 16'(INIT_FC) + (cfg_q.startup_delay_select ? 16'(SD_FC) : 16'h0000);
	wire init_done = in_init && init_cnt_q >= init_len;
	wire [4:0] first_blk = cfg_q.last_cyclic_block == 5'h00 ? 5'h00 : BLK_FIRST;

	// uplink entry: block and repeat mode chosen by cause
	wire up_go = init_done || err_bit || vfy_ok || (frame_end && !rst_cmd && !go_prog);
	wire up_rep = vfy_ok || dec_rep;
	wire [4:0] up_blk = vfy_ok ? tgt_q : dec_rep ? frame_addr : init_done ? first_blk : BLK_FIRST;

	// cyclic advance through blocks 1..last, or block 0 alone
	wire blk_end = in_up && bit_next && !start_q && idx_q == 5'h1F;
	wire [4:0] nxt_blk = rep_q ? blk_q :
		cfg_q.last_cyclic_block == 5'h00 ? 5'h00 :
		blk_q >= cfg_q.last_cyclic_block ? BLK_FIRST : blk_q + 5'h01;
	wire ul_bit = start_q ? 1'b0 : rd_word[5'h1F - idx_q];

	wire [4:0] rd_addr = in_down ? frame_addr : in_prog ? tgt_q : blk_q;

	// one driver for the whole write request
	assign wr = '{we: prog_due, addr: tgt_q, word: word_q};

	always_comb begin
		st_d = st_q;
		unique case (st_q)
			ST_INIT: begin
				if (init_done) st_d = ST_UP;
			end
			ST_UP, ST_SILENT: begin
				if (start_gap) st_d = ST_DOWN;
			end
			ST_DOWN: begin
				if (rst_cmd) st_d = ST_INIT;
				else if (go_prog) st_d = ST_PROG;
				else if (err_bit || frame_end) st_d = ST_UP;
			end
			ST_PROG: begin
				if (vfy_ok) st_d = ST_UP;
				else if (vfy_bad) st_d = ST_SILENT;
			end
			default: st_d = ST_INIT;
		endcase
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			st_q <= ST_INIT;
		end else begin
			st_q <= st_d;
		end
	end

	// gap length in system clocks, counted while the field is off
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			gap_len_q <= 16'h0000;
		end else if (!gap_s) begin
			gap_len_q <= 16'h0000;
		end else if (gap_len_q != 16'hFFFF) begin
			gap_len_q <= gap_len_q + 16'h0001;
		end
	end

	// init timer restarts on any gap; configuration is reloaded meanwhile
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			init_cnt_q <= 16'h0000;
		end else if (!in_init || gap_rise) begin
			init_cnt_q <= 16'h0000;
		end else if (fc_tick) begin
			init_cnt_q <= init_cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			cfg_q <= tcp_cfg_of(CFG_RESET);
		end else if (in_init || up_go || blk_end) begin
			cfg_q <= tcp_cfg_of(cfg_word);
		end
	end

	// interval counter between gaps, saturating
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			ivl_q <= 8'h00;
		end else if (!in_down || gap_fall) begin
			ivl_q <= 8'h00;
		end else if (fc_tick && ivl_q != 8'hFF) begin
			ivl_q <= ivl_q + 8'h01;
		end
	end

	// receive shift register, bit count and opcode capture
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			rx_q <= 40'h00_0000_0000;
			cnt_q <= 6'h00;
			op_q <= 2'h0;
		end else if (!in_down) begin
			cnt_q <= 6'h00;
		end else if (gap_rise && (is_zero || is_one)) begin
			rx_q <= {rx_q[38:0], new_bit};
			if (cnt_q != 6'h3F) cnt_q <= cnt_q + 6'h01;
			if (cnt_q == 6'h01) op_q <= {rx_q[0], new_bit};
		end
	end

	// target and data of a write, and the program timer
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			tgt_q <= 5'h00;
			word_q <= BLK_RESET;
			prog_cnt_q <= 16'h0000;
			vfy_q <= 1'b0;
		end else if (go_prog) begin
			tgt_q <= frame_addr;
			word_q <= frame_word;
			prog_cnt_q <= 16'h0000;
			vfy_q <= 1'b0;
		end else if (in_prog) begin
			if (prog_due) vfy_q <= 1'b1;
			else if (fc_tick && prog_cnt_q != 16'(PROG_FC)) prog_cnt_q <= prog_cnt_q + 16'h0001;
		end
	end

	// uplink block/bit pointer, preceded by one start bit
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			blk_q <= BLK_FIRST;
			idx_q <= 5'h00;
			rep_q <= 1'b0;
			start_q <= 1'b1;
			mod_restart_q <= 1'b0;
		end else begin
			mod_restart_q <= up_go;
			if (up_go) begin
				blk_q <= up_blk;
				rep_q <= up_rep;
				idx_q <= 5'h00;
				start_q <= 1'b1;
			end else if (in_up && bit_next) begin
				if (start_q) begin
					start_q <= 1'b0;
				end else begin
					idx_q <= idx_q + 5'h01;
					if (blk_end) blk_q <= nxt_blk;
				end
			end
		end
	end

	// pin drivers: damping on in downlink only, modulation only in uplink
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			DAMP_ON <= 1'b0;
			MOD_OUT <= 1'b0;
			STATE <= ST_INIT;
		end else begin
			DAMP_ON <= in_down;
			MOD_OUT <= in_up && !cfg_q.output_silence && mod_w;
			STATE <= st_q;
		end
	end

	tcp_nvm_array u_array (
		.clk(CLOCK),
		.rst_n(RSTN),
		.wr(wr),
		.fault(prog_fault),
		.rd_addr(rd_addr),
		.rd_word(rd_word),
		.cfg_word(cfg_word)
	);

	tcp_modulator u_mod (
		.clk(CLOCK),
		.rst_n(RSTN),
		.fc_tick(fc_tick),
		.restart(mod_restart_q),
		.rate_sel(cfg_q.rate_select),
		.enc_sel(cfg_q.encoding_select),
		.bit_in(ul_bit),
		.mod(mod_w),
		.bit_next(bit_next)
	);

	sequence s_write;
		prog_due ##1 vfy_q;
	endsequence

	sequence s_leave_prog;
		st_d == ST_UP || st_d == ST_SILENT;
	endsequence

	a_prog_damp: assert property (in_prog |=> !DAMP_ON)
		else $error("damping on while programming");
	a_silent_mute: assert property (in_silent |=> !MOD_OUT)
		else $error("modulation in silent state");
	a_silence_cfg: assert property (cfg_q.output_silence |=> !MOD_OUT)
		else $error("modulation while silenced");
	a_lock_write: assert property (wr.we |-> !rd_word[LOCK_POS])
		else $error("write issued to locked block");
	a_write_len: assert property (in_down && st_d == ST_PROG |->
		(op_q == OP_W5 && cnt_q == LEN_W5) || (op_q == OP_W3 && cnt_q == LEN_W3))
		else $error("programming on bad frame length");
	a_bit_error: assert property (err_bit |=> in_up && blk_q == BLK_FIRST && !rep_q)
		else $error("bit error not sent to block 1");
	a_start_gap: assert property (start_gap |=> in_down ##1 DAMP_ON)
		else $error("start gap did not enter downlink");
	a_verify_up: assert property (vfy_ok |=> in_up && rep_q && blk_q == $past(tgt_q))
		else $error("verified block not sent");
	a_reset_op: assert property (rst_cmd |=> in_init)
		else $error("reset opcode ignored");
	a_prog_verify: assert property (s_write |-> s_leave_prog)
		else $error("verify did not end programming");
	a_direct_rep: assert property (frame_end && acc_da |=> rep_q && blk_q == $past(frame_addr))
		else $error("direct access not repeated");
endmodule

// ==== hdl/tcp_pkg.sv ====
package tcp_pkg;
	localparam int CLK_KHZ = 125000;
	localparam int FC_KHZ = 125;
	localparam int INIT_FC = 114;
	localparam int SD_TIME_MS = 64;
	localparam int SD_FC_DEF = 8192;
	localparam int PROG_TIME_US = 18000;
	localparam int PROG_FC_DEF = PROG_TIME_US * FC_KHZ / 1000;
	localparam int START_GAP_US = 150;
	localparam int START_GAP_CYC_DEF = START_GAP_US * CLK_KHZ / 1000;
	localparam logic [7:0] ZERO_MIN = 8'h10;
	localparam logic [7:0] ZERO_MAX = 8'h20;
	localparam logic [7:0] ONE_MIN = 8'h30;
	localparam logic [7:0] ONE_MAX = 8'h40;
	localparam logic [5:0] LEN_W5 = 6'h28;
	localparam logic [5:0] LEN_W3 = 6'h26;
	localparam logic [5:0] LEN_DA = 6'h07;
	localparam logic [1:0] OP_W5 = 2'h3;
	localparam logic [1:0] OP_W3 = 2'h2;
	localparam logic [1:0] OP_TEST = 2'h1;
	localparam logic [1:0] OP_RST = 2'h0;
	localparam int NBLK = 32;
	localparam int LOCK_POS = 32;
	localparam int SD_POS = 9;
	localparam int DR_POS = 8;
	localparam int MS_POS = 7;
	localparam int MD_POS = 6;
	localparam int LAST_LSB = 1;
	localparam logic [32:0] CFG_RESET = 33'h0_0000_003E;
	localparam logic [32:0] BLK_RESET = 33'h0_0000_0000;
	localparam logic [4:0] BLK_FIRST = 5'h01;
	localparam logic [5:0] PER_FAST = 6'h10;
	localparam logic [5:0] PER_SLOW = 6'h20;
	typedef struct packed {
		logic startup_delay_select;
		logic rate_select;
		logic encoding_select;
		logic output_silence;
		logic [4:0] last_cyclic_block;
	} tcp_cfg_t;
	typedef struct packed {
		logic we;
		logic [4:0] addr;
		logic [32:0] word;
	} tcp_wr_t;
	typedef enum logic [4:0] {
		ST_INIT = 5'h01,
		ST_UP = 5'h02,
		ST_DOWN = 5'h04,
		ST_PROG = 5'h08,
		ST_SILENT = 5'h10
	} tcp_state_t;
	function automatic tcp_cfg_t tcp_cfg_of(input logic [32:0] w);
		tcp_cfg_t c;
		c.startup_delay_select = w[SD_POS];
		c.rate_select = w[DR_POS];
		c.encoding_select = w[MS_POS];
		c.output_silence = w[MD_POS];
		c.last_cyclic_block = w[LAST_LSB+:5];
		return c;
	endfunction
endpackage

// ==== hdl/tcp_nvm_array.sv ====
`timescale 1ns/1ps
module tcp_nvm_array (
	input wire logic clk,
	input wire logic rst_n,
	input wire tcp_pkg::tcp_wr_t wr,
	input wire logic fault,
	input wire logic [4:0] rd_addr,
	output logic [32:0] rd_word,
	output logic [32:0] cfg_word
);
	import tcp_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [32:0] mem_q [NBLK];
	// a weak cell corrupts the low data bit so that verify catches it
	wire [32:0] wr_word = fault ? {wr.word[32:1], ~wr.word[0]} : wr.word;
	for (genvar i = 0; i < NBLK; i++) begin : g_blk
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				mem_q[i] <= (i == 0) ? CFG_RESET : BLK_RESET;
			end else if (wr.we && wr.addr == 5'(i) && !mem_q[i][LOCK_POS]) begin
				mem_q[i] <= wr_word;
			end
		end
		a_lock_hold: assert property (mem_q[i][LOCK_POS] |=> mem_q[i] == $past(mem_q[i]))
			else $error("locked block changed");
	end
	assign rd_word = mem_q[rd_addr];
	assign cfg_word = mem_q[0];
endmodule

// ==== hdl/tcp_modulator.sv ====
`timescale 1ns/1ps
module tcp_modulator (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic fc_tick,
	input wire logic restart,
	input wire logic rate_sel,
	input wire logic enc_sel,
	input wire logic bit_in,
	output logic mod,
	output logic bit_next
);
	import tcp_pkg::*;
	logic [5:0] ph_q;
	logic bit_q;
	logic ld_q;
	logic sub_q;
	logic phase_q;
	wire [5:0] per = rate_sel ? PER_SLOW : PER_FAST;
	wire [5:0] half = {1'b0, per[5:1]};
	wire ph_last = ph_q == per - 6'h01;
	assign bit_next = fc_tick && ph_last && !restart;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_q <= 6'h00;
			sub_q <= 1'b0;
		end else if (restart) begin
			ph_q <= 6'h00;
			sub_q <= 1'b0;
		end else if (fc_tick) begin
			ph_q <= ph_last ? 6'h00 : ph_q + 6'h01;
			sub_q <= ~sub_q;
		end
	end
	// the new bit is loaded one cycle after the request, once the source has moved on
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ld_q <= 1'b0;
			bit_q <= 1'b0;
			phase_q <= 1'b0;
		end else begin
			ld_q <= bit_next || restart;
			if (restart) begin
				bit_q <= 1'b0;
				phase_q <= 1'b0;
			end else if (ld_q) begin
				bit_q <= bit_in;
				phase_q <= phase_q ^ (bit_in ^ bit_q);
			end
		end
	end
	// manchester: one rises at mid-bit, zero falls; psk flips the rf/2 sub-carrier on change
	assign mod = enc_sel ? ((ph_q < half) ? ~bit_q : bit_q) : (sub_q ^ phase_q);
endmodule

// ==== verif/tcp_reader_model.sv ====
`timescale 1ns/1ps
module tcp_reader_model (
	input wire logic clk,
	output logic field_clk,
	output logic field_gap
);
	logic [3:0] div_q;
	initial begin
		field_clk = 1'b0;
		field_gap = 1'b0;
		div_q = 4'h0;
	end
	// carrier stands still while the field is interrupted
	always @(posedge clk) begin
		if (field_gap) begin
			div_q <= 4'h0;
			field_clk <= 1'b0;
		end else if (div_q == 4'h9) begin
			div_q <= 4'h0;
			field_clk <= ~field_clk;
		end else begin
			div_q <= div_q + 4'h1;
		end
	end
	task automatic gap(input int cyc);
		@(posedge clk);
		field_gap <= 1'b1;
		repeat (cyc) @(posedge clk);
		field_gap <= 1'b0;
	endtask
	task automatic field(input int fc);
		repeat (fc * 20) @(posedge clk);
	endtask
	// each bit is the field-on time closed by a normal gap
	task automatic send(input logic [39:0] v, input int n);
		gap(250);
		for (int i = n - 1; i >= 0; i--) begin
			field(v[i] ? 50 : 18);
			gap(30);
		end
	endtask
endmodule

// ==== verif/tb_transponder_command_program_ctrl.sv ====
`timescale 1ns/1ps
module tb_transponder_command_program_ctrl;
	import tcp_pkg::*;
	logic clock;
	logic rstn;
	logic prog_fault;
	logic field_clk;
	logic field_gap;
	logic damp_on;
	logic mod_out;
	tcp_state_t state;
	logic saw_prog;
	int miscompares;
	int checks;
	tcp_ctrl #(.START_GAP_CYC(200), .SD_FC(20), .PROG_FC(10)) dut_u (
		.CLOCK(clock),
		.RSTN(rstn),
		.FIELD_CLK(field_clk),
		.FIELD_GAP(field_gap),
		.PROG_FAULT(prog_fault),
		.DAMP_ON(damp_on),
		.MOD_OUT(mod_out),
		.STATE(state)
	);
	tcp_reader_model rd_u (.clk(clock), .field_clk(field_clk), .field_gap(field_gap));
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	task automatic close_out();
		if (miscompares == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wait_state(input tcp_state_t st, input int lim);
		int n;
		n = 0;
		saw_prog = 1'b0;
		while (state !== st && n < lim) begin
			@(posedge clock);
			#1;
			if (state === ST_PROG) saw_prog = 1'b1;
			n++;
		end
		check(33'(state), 33'(st));
	endtask
	// manchester at 16 field clocks a bit: sample late in each bit
	task automatic read_back(input logic [31:0] w, input bit rep);
		logic [64:0] s;
		int lo;
		s = {1'b0, w, w};
		lo = rep ? 0 : 32;
		#1920;
		for (int k = 64; k >= lo; k--) begin
			check(33'(mod_out), 33'(s[k]));
			if (k > lo) #2560;
		end
	endtask
	task automatic t_init();
		#16801;
		check(33'(state), 33'(ST_INIT));
		wait_state(ST_UP, 400);
	endtask
	task automatic t_cfg();
		// startup delay, manchester, last block 31, reserved bits zero
		rd_u.send({2'b11, 1'b0, 32'h0000_02BE, 5'h00}, 40);
		wait_state(ST_PROG, 1600);
		check(33'(damp_on), 33'h0);
		wait_state(ST_UP, 600);
	endtask
	task automatic t_short_write();
		rd_u.send({2'b0, 2'b10, 1'b1, 32'h8000_0011, 3'h2}, 38);
		wait_state(ST_PROG, 1600);
		wait_state(ST_UP, 600);
		read_back(32'h8000_0011, 1'b0);
	endtask
	task automatic t_locked();
		rd_u.send({2'b11, 1'b0, 32'h0, 5'h02}, 40);
		wait_state(ST_UP, 2000);
		check(33'(saw_prog), 33'h0);
		read_back(32'h8000_0011, 1'b0);
	endtask
	task automatic t_direct();
		rd_u.send({33'h0, 2'b11, 5'h00}, 7);
		wait_state(ST_UP, 2000);
		check(33'(saw_prog), 33'h0);
		read_back(32'h0000_02BE, 1'b1);
	endtask
	task automatic t_fault();
		@(posedge clock);
		prog_fault <= 1'b1;
		rd_u.send({2'b11, 1'b0, 32'h0, 5'h05}, 40);
		wait_state(ST_SILENT, 2000);
		repeat (20) begin
			#160;
			check(33'(mod_out), 33'h0);
		end
		@(posedge clock);
		prog_fault <= 1'b0;
		rd_u.gap(250);
		#41;
		check(33'(state), 33'(ST_DOWN));
		check(33'(damp_on), 33'h1);
		rd_u.field(40);
		rd_u.gap(30);
		wait_state(ST_UP, 200);
	endtask
	task automatic t_frame();
		rd_u.send(40'h0_0000_0300, 10);
		wait_state(ST_UP, 2000);
		check(33'(saw_prog), 33'h0);
	endtask
	task automatic t_reset();
		rd_u.send(40'h0, 2);
		wait_state(ST_INIT, 1600);
		check(33'(damp_on), 33'h0);
		#19200;
		check(33'(state), 33'(ST_INIT));
		wait_state(ST_UP, 800);
	endtask
	initial begin
		rstn = 1'b0;
		prog_fault = 1'b0;
		saw_prog = 1'b0;
		miscompares = 0;
		checks = 0;
		repeat (2) @(posedge clock);
		#1;
		check(33'(state), 33'(ST_INIT));
		check(33'(damp_on), 33'h0);
		check(33'(mod_out), 33'h0);
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		t_init();
		t_cfg();
		t_short_write();
		t_locked();
		t_direct();
		t_fault();
		t_frame();
		t_reset();
		close_out();
	end
	// cut a hang short well past the expected run length
	initial begin
		#2500000;
		miscompares++;
		close_out();
	end
endmodule
